// ===== design/sac_pkg.sv
// Function
// - conversions run only while enable is set; clearing enable stops them
// - reference select reaches the converter whether enabled or not
// - ten-bit result split over two bytes, right aligned unless left adjust set
// - software reads low byte before high byte; low read freezes both bytes
// - result finishing while frozen is dropped, both bytes unchanged
// - reading high byte unfreezes the result bytes
// - completion flag rises on every completion, dropped result included
// - writing start begins one conversion; bit reads set until completion
// - channel change during conversion applies only after it completes
// - auto trigger enable lets selected hardware trigger start conversions
// - rising trigger edge restarts the prescaler and starts a conversion
// - trigger still high at completion starts nothing; only a new edge
// - trigger edges during a conversion are dropped, never queued
// - source flags set even when masked; software clears them between triggers
// - completion flag as trigger gives back-to-back runs after first start, single ended channels only
// - start write works with auto trigger; start reads one while busy
// - channel field picks eleven pins, ground or bandgap, single ended
// - two differential pairs with gain five, ten, twenty or forty
// - normal conversion thirteen converter clocks, first after enable 25
// - completion stores result unless frozen, sets flag and, outside free running, clears start together
// - prescaler counts while enabled, held in reset while disabled
package sac_pkg;

   // register byte offsets
   localparam logic [7:0] SAC_OFF_CHREF = 8'h00;
   localparam logic [7:0] SAC_OFF_CTLA  = 8'h04;
   localparam logic [7:0] SAC_OFF_CTLB  = 8'h08;
   localparam logic [7:0] SAC_OFF_RLOW  = 8'h0C;
   localparam logic [7:0] SAC_OFF_RHIGH = 8'h10;

   // channel_reference_register fields
   localparam int CR_CH_LSB  = 0;
   localparam int CR_LADJ    = 5;
   localparam int CR_REF_LSB = 6;

   // converter_control_a fields
   localparam int CA_PS_LSB = 0;
   localparam int CA_IE     = 3;
   localparam int CA_FLAG   = 4;
   localparam int CA_ATE    = 5;
   localparam int CA_START  = 6;
   localparam int CA_EN     = 7;

   // converter_control_b fields
   localparam int CB_TS_LSB   = 0;
   localparam int CB_GAIN_LSB = 4;

   // converter clock counts per conversion (13 and 25)
   localparam logic [4:0] SAC_NORMAL_CYC = 5'h0D;
   localparam logic [4:0] SAC_FIRST_CYC  = 5'h19;

   // trigger source 0 is the completion flag itself
   localparam logic [2:0] SAC_TS_FREE = 3'h0;

   // channel codes; 0 to 10 are the pins
   localparam logic [3:0] SAC_CH_DIFF0   = 4'hB;
   localparam logic [3:0] SAC_CH_DIFF1   = 4'hC;
   localparam logic [3:0] SAC_CH_BANDGAP = 4'hE;
   localparam logic [3:0] SAC_CH_GND     = 4'hF;

   typedef enum logic [1:0] {
      SAC_ST_IDLE = 2'b00,
      SAC_ST_WAIT = 2'b01,
      SAC_ST_CONV = 2'b10
   } sac_state_t;

   typedef struct packed {
      sac_state_t st;
      logic [4:0] cnt;
      logic       first;
      logic       en;
      logic       ate;
      logic       ie;
      logic [2:0] ps;
      logic [3:0] chan;
      logic       ladj;
      logic [1:0] refs;
      logic [2:0] tsel;
      logic [1:0] gain;
      logic [9:0] res;
      logic       lock;
      logic       flag;
      logic       trig_prev;
      logic [3:0] act_ch;
      logic [1:0] act_ref;
      logic [1:0] act_gain;
      logic       start_p;
      logic       ack;
      logic [7:0] dat;
   } sac_regs_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } sac_psc_t;

   localparam sac_regs_t SAC_REGS_RST = '{st: SAC_ST_IDLE, first: 1'b1, default: '0};
   localparam sac_psc_t  SAC_PSC_RST  = '{default: '0};

endpackage

// ===== design/sac_presc_if.sv
`timescale 1ns/1ps
interface sac_presc_if;
   logic       enable;
   logic       restart;
   logic [2:0] div_sel;
   logic       tick;

   modport ctl (output enable, output restart, output div_sel, input tick);
   modport psc (input enable, input restart, input div_sel, output tick);
endinterface

// ===== design/sac_prescaler.sv
`timescale 1ns/1ps
module sac_prescaler
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   sac_presc_if.psc pif
);

   sac_psc_t   q;
   sac_psc_t   n;
   logic [7:0] term;

   // divide by 2 for selects 0 and 1, else 2 to the select
   always_comb begin
      term = (pif.div_sel == 3'h0) ? 8'h01 : (8'h01 << pif.div_sel) - 8'h01;
   end

   // >= so a smaller divider chosen mid-count does not wrap through 255
   always_comb begin
      n      = q;
      n.tick = 1'b0;
      if (!pif.enable || pif.restart) begin
         n.cnt = 8'h00;
      end else if (q.cnt >= term) begin
         n.cnt  = 8'h00;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= SAC_PSC_RST;
      end else begin
         q <= n;
      end
   end

   assign pif.tick = q.tick;

   held_in_reset_a: assert property (
      @(posedge clk) disable iff (reset)
      !pif.enable |=> (q.cnt == 8'h00) && !pif.tick)
      else $error("prescaler ran while converter disabled");

   restart_gap_a: assert property (
      @(posedge clk) disable iff (reset)
      (pif.restart && pif.enable) |=> !pif.tick [*2])
      else $error("tick too soon after prescaler restart");

endmodule

// ===== design/sac_top.sv
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module sac_top
   import sac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output wire logic [31:0] wb_dat_o,
   output wire logic        wb_ack_o,
   input  wire logic [7:0]  trig_in,
   input  wire logic [9:0]  analog_result,
   input  wire logic        vector_taken,
   output wire logic        conv_irq,
   output wire logic        converter_on,
   output wire logic [3:0]  active_channel,
   output wire logic [1:0]  active_reference,
   output wire logic [1:0]  active_gain,
   output wire logic        sample_start,
   output wire logic        conv_busy
);

   sac_regs_t   q;
   sac_regs_t   n;
   sac_presc_if psc ();

   logic       acc;
   logic       wr;
   logic       rd;
   logic       wr_a;
   logic       start_wr;
   logic       en_nxt;
   logic       busy;
   logic       trig_lvl;
   logic       trig_edge;
   logic       trig_go;
   logic       done;
   logic       is_diff;
   logic       free_run;
   logic [4:0] conv_len;
   logic [7:0] res_hi;
   logic [7:0] res_lo;
   logic [7:0] rd_mux;

   // bus decode; one access per request, ack drops the next cycle
   assign acc = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wr  = acc & wb_we_i & wb_sel_i[0];
   assign rd  = acc & ~wb_we_i;

   // control register write and start request
   assign wr_a     = wr && (wb_adr_i == SAC_OFF_CTLA);
   assign start_wr = wr_a && wb_dat_i[CA_START];
   assign en_nxt   = wr_a ? wb_dat_i[CA_EN] : q.en;

   assign busy = (q.st != SAC_ST_IDLE);

   // trigger sources share our clock, so no synchroniser is needed
   assign trig_lvl  = trig_in[q.tsel];
   assign trig_edge = q.ate && (q.tsel != SAC_TS_FREE) && trig_lvl && !q.trig_prev;

   // edges outside idle fall on the floor instead of queueing
   assign trig_go = trig_edge && q.en && !busy;

   // the first run after enable needs extra clocks to settle
   assign conv_len = q.first ? SAC_FIRST_CYC : SAC_NORMAL_CYC;

   assign done = (q.st == SAC_ST_CONV) && psc.tick && (q.cnt == conv_len - 5'h01);

   // amplified pairs cannot chain; the amplifier ends each run
   assign is_diff  = (q.act_ch == SAC_CH_DIFF0) || (q.act_ch == SAC_CH_DIFF1);
   assign free_run = q.ate && (q.tsel == SAC_TS_FREE) && !is_diff;

   // prescaler follows enable and is restarted by a trigger
   assign psc.enable  = q.en;
   assign psc.restart = trig_go;
   assign psc.div_sel = q.ps;

   sac_prescaler u_presc (
      .clk   (clk),
      .reset (reset),
      .pif   (psc)
   );

   // alignment applied at read time, so left adjust acts at once
   assign res_hi = q.ladj ? q.res[9:2] : {6'h00, q.res[9:8]};
   assign res_lo = q.ladj ? {q.res[1:0], 6'h00} : q.res[7:0];

   // read data mux; start bit shows any conversion in flight
   always_comb begin
      case (wb_adr_i)
         SAC_OFF_CHREF: begin
            rd_mux = {q.refs, q.ladj, 1'b0, q.chan};
         end
         SAC_OFF_CTLA: begin
            rd_mux = {q.en, busy, q.ate, q.flag, q.ie, q.ps};
         end
         SAC_OFF_CTLB: begin
            rd_mux = {2'b00, q.gain, 1'b0, q.tsel};
         end
         SAC_OFF_RLOW: begin
            rd_mux = res_lo;
         end
         SAC_OFF_RHIGH: begin
            rd_mux = res_hi;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // next state of the whole block
   always_comb begin
      n           = q;
      n.ack       = acc;
      n.start_p   = 1'b0;
      n.trig_prev = trig_lvl;

      // software writes; result bytes are read only
      if (wr) begin
         case (wb_adr_i)
            SAC_OFF_CHREF: begin
               n.chan = wb_dat_i[CR_CH_LSB +: 4];
               n.ladj = wb_dat_i[CR_LADJ];
               n.refs = wb_dat_i[CR_REF_LSB +: 2];
            end
            SAC_OFF_CTLA: begin
               n.en  = wb_dat_i[CA_EN];
               n.ate = wb_dat_i[CA_ATE];
               n.ie  = wb_dat_i[CA_IE];
               n.ps  = wb_dat_i[CA_PS_LSB +: 3];
            end
            SAC_OFF_CTLB: begin
               n.tsel = wb_dat_i[CB_TS_LSB +: 3];
               n.gain = wb_dat_i[CB_GAIN_LSB +: 2];
            end
            default: begin
            end
         endcase
      end

      // low read freezes the pair, high read releases it
      if (rd) begin
         n.dat = rd_mux;
         if (wb_adr_i == SAC_OFF_RLOW) begin
            n.lock = 1'b1;
         end
         if (wb_adr_i == SAC_OFF_RHIGH) begin
            n.lock = 1'b0;
         end
      end

      // flag clears come first so a completion in the same cycle wins
      if (wr_a && wb_dat_i[CA_FLAG]) begin
         n.flag = 1'b0;
      end
      if (vector_taken && q.ie) begin
         n.flag = 1'b0;
      end

      // selections follow software except while converting
      if (q.st != SAC_ST_CONV) begin
         n.act_ch   = q.chan;
         n.act_ref  = q.refs;
         n.act_gain = q.gain;
      end

      // conversion sequencer
      case (q.st)
         SAC_ST_IDLE: begin
            if (trig_go || (start_wr && en_nxt)) begin
               n.st = SAC_ST_WAIT;
            end
         end
         SAC_ST_WAIT: begin
            if (psc.tick) begin
               n.st      = SAC_ST_CONV;
               n.cnt     = 5'h00;
               n.start_p = 1'b1;
            end
         end
         SAC_ST_CONV: begin
            if (done) begin
               n.flag  = 1'b1;
               n.first = 1'b0;
               // selection reopens at completion, else a free run never sees a new channel
               n.act_ch   = q.chan;
               n.act_ref  = q.refs;
               n.act_gain = q.gain;
               if (!q.lock) begin
                  n.res = analog_result;
               end
               if (free_run) begin
                  n.cnt     = 5'h00;
                  n.start_p = 1'b1;
               end else begin
                  n.st = SAC_ST_IDLE;
               end
            end else if (psc.tick) begin
               n.cnt = q.cnt + 5'h01;
            end
         end
         default: begin
            n.st = SAC_ST_IDLE;
         end
      endcase

      // disabling aborts any run and rearms the long first conversion
      if (!en_nxt) begin
         n.st      = SAC_ST_IDLE;
         n.cnt     = 5'h00;
         n.first   = 1'b1;
         n.start_p = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= SAC_REGS_RST;
      end else begin
         q <= n;
      end
   end

   // outputs
   assign wb_dat_o         = {24'h00_0000, q.dat};
   assign wb_ack_o         = q.ack;
   assign conv_irq         = q.flag & q.ie;
   assign converter_on     = q.en;
   assign active_channel   = q.act_ch;
   assign active_reference = q.act_ref;
   assign active_gain      = q.act_gain;
   assign sample_start     = q.start_p;
   assign conv_busy        = busy;

   // checks on the bus answer

   ack_single_a: assert property (
      @(posedge clk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // checks on the conversion control

   run_needs_en_a: assert property (
      @(posedge clk) disable iff (reset)
      busy |-> q.en)
      else $error("conversion active while disabled");

   frozen_keep_a: assert property (
      @(posedge clk) disable iff (reset)
      (done && q.lock) |=> $stable(q.res))
      else $error("frozen result was overwritten");

   low_read_lock_a: assert property (
      @(posedge clk) disable iff (reset)
      (rd && (wb_adr_i == SAC_OFF_RLOW)) |=> q.lock)
      else $error("low byte read did not freeze result");

   high_read_free_a: assert property (
      @(posedge clk) disable iff (reset)
      (rd && (wb_adr_i == SAC_OFF_RHIGH)) |=> !q.lock)
      else $error("high byte read did not release result");

   flag_on_done_a: assert property (
      @(posedge clk) disable iff (reset)
      done |=> q.flag)
      else $error("completion flag not raised");

   start_clears_a: assert property (
      @(posedge clk) disable iff (reset)
      (done && !free_run && en_nxt) |=> !conv_busy && q.flag)
      else $error("start bit not cleared with the flag");

   chan_hold_a: assert property (
      @(posedge clk) disable iff (reset)
      ((q.st == SAC_ST_CONV) && !done) ##1 (q.st == SAC_ST_CONV) |-> $stable(q.act_ch))
      else $error("channel changed during conversion");

   edge_ignored_a: assert property (
      @(posedge clk) disable iff (reset)
      ((q.st == SAC_ST_CONV) && trig_edge && !done && en_nxt) |=> (q.st == SAC_ST_CONV))
      else $error("trigger edge disturbed a running conversion");

   trig_start_a: assert property (
      @(posedge clk) disable iff (reset)
      (trig_go && en_nxt) |-> psc.restart ##1 (q.st == SAC_ST_WAIT))
      else $error("trigger edge did not start a conversion");

   level_no_start_a: assert property (
      @(posedge clk) disable iff (reset)
      (!busy && trig_lvl && q.trig_prev && !start_wr) |=> !busy)
      else $error("held trigger level started a conversion");

   free_chain_a: assert property (
      @(posedge clk) disable iff (reset)
      (done && free_run && en_nxt) |=> (q.st == SAC_ST_CONV) && (q.cnt == 5'h00) && sample_start)
      else $error("free running conversion did not chain");

   sw_start_a: assert property (
      @(posedge clk) disable iff (reset)
      (start_wr && en_nxt && !busy) |=> (q.st == SAC_ST_WAIT) && conv_busy)
      else $error("start write ignored");

   first_long_a: assert property (
      @(posedge clk) disable iff (reset)
      ((q.st == SAC_ST_CONV) && q.first && psc.tick && (q.cnt < SAC_FIRST_CYC - 5'h01) && en_nxt)
      |=> (q.st == SAC_ST_CONV))
      else $error("first conversion ended early");

   vector_clear_a: assert property (
      @(posedge clk) disable iff (reset)
      (vector_taken && q.ie && !done) |=> !q.flag)
      else $error("vector taken did not clear flag");

   ref_follow_a: assert property (
      @(posedge clk) disable iff (reset)
      (!q.en && !busy) |=> (active_reference == $past(q.refs)))
      else $error("reference not applied while disabled");

   diff_no_chain_a: assert property (
      @(posedge clk) disable iff (reset)
      (done && is_diff) |=> !conv_busy)
      else $error("amplified channel chained a conversion");

   disable_stop_a: assert property (
      @(posedge clk) disable iff (reset)
      !en_nxt |=> !conv_busy && !sample_start)
      else $error("conversion kept running after disable");

   sel_follow_a: assert property (
      @(posedge clk) disable iff (reset)
      (q.st != SAC_ST_CONV) |=> (active_channel == $past(q.chan)))
      else $error("channel selection not followed while idle");

   result_store_a: assert property (
      @(posedge clk) disable iff (reset)
      (done && !q.lock) |=> (q.res == $past(analog_result)))
      else $error("result not stored at completion");

endmodule

// ===== bench/tb_sac_top.sv
`timescale 1ns/1ps
module tb_sac_top
   import sac_pkg::*;
;
   logic        clk;
   logic        reset;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [7:0]  trig_in;
   logic [9:0]  analog_result;
   logic        vector_taken;
   logic        conv_irq;
   logic        converter_on;
   logic [3:0]  active_channel;
   logic [1:0]  active_reference;
   logic [1:0]  active_gain;
   logic        sample_start;
   logic        conv_busy;
   logic [7:0]  ctla_v;
   logic [31:0] q;
   int          n;
   int          miscompares;
   int          n_checks;

   sac_top u_dut (
      .clk              (clk),
      .reset            (reset),
      .wb_cyc_i         (wb_cyc_i),
      .wb_stb_i         (wb_stb_i),
      .wb_we_i          (wb_we_i),
      .wb_adr_i         (wb_adr_i),
      .wb_sel_i         (wb_sel_i),
      .wb_dat_i         (wb_dat_i),
      .wb_dat_o         (wb_dat_o),
      .wb_ack_o         (wb_ack_o),
      .trig_in          (trig_in),
      .analog_result    (analog_result),
      .vector_taken     (vector_taken),
      .conv_irq         (conv_irq),
      .converter_on     (converter_on),
      .active_channel   (active_channel),
      .active_reference (active_reference),
      .active_gain      (active_gain),
      .sample_start     (sample_start),
      .conv_busy        (conv_busy)
   );

   // free running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic results();
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'h1;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask

   // start by software, count cycles while busy
   task automatic run(input logic [9:0] r, output int c);
      c = 0;
      analog_result <= r;
      wr(SAC_OFF_CTLA, ctla_v | 8'h40);
      while (conv_busy === 1'b1 && c < 200) begin
         @(posedge clk);
         c++;
      end
   endtask

   task automatic t_basic();
      wb(1'b0, SAC_OFF_CTLA, 8'h00, q);
      chk(q, 32'h0000_0000);
      wb(1'b0, 8'h14, 8'h00, q);
      chk(q, 32'h0000_0000);
      wr(SAC_OFF_CHREF, 8'h83);
      chk(32'(active_reference), 32'h0000_0002);
      chk(32'(active_channel), 32'h0000_0003);
      ctla_v = 8'h80;
      run(10'h2A5, n);
      chk(32'(n >= 44 && n <= 56), 32'h0000_0001);
      wb(1'b0, SAC_OFF_CTLA, 8'h00, q);
      chk(q, 32'h0000_0090);
      wb(1'b0, SAC_OFF_RLOW, 8'h00, q);
      chk(q, 32'h0000_00A5);
      wb(1'b0, SAC_OFF_RHIGH, 8'h00, q);
      chk(q, 32'h0000_0002);
      chk(32'(converter_on), 32'h0000_0001);
      run(10'h111, n);
      chk(32'(n >= 20 && n <= 32), 32'h0000_0001);
   endtask

   // low read freezes both bytes until the high byte is read
   task automatic t_lock();
      wr(SAC_OFF_CHREF, 8'hA3);
      run(10'h3C1, n);
      wb(1'b0, SAC_OFF_RLOW, 8'h00, q);
      chk(q, 32'h0000_0040);
      wr(SAC_OFF_CTLA, 8'h90);
      run(10'h2AA, n);
      wb(1'b0, SAC_OFF_CTLA, 8'h00, q);
      chk(q, 32'h0000_0090);
      wb(1'b0, SAC_OFF_RHIGH, 8'h00, q);
      chk(q, 32'h0000_00F0);
      run(10'h2AA, n);
      wb(1'b0, SAC_OFF_RLOW, 8'h00, q);
      chk(q, 32'h0000_0080);
      wb(1'b0, SAC_OFF_RHIGH, 8'h00, q);
      chk(q, 32'h0000_00AA);
   endtask

   task automatic t_chan();
      wr(SAC_OFF_CTLA, ctla_v | 8'h40);
      chk(32'(conv_busy), 32'h0000_0001);
      repeat (6) @(posedge clk); // past the first converter tick
      wr(SAC_OFF_CHREF, 8'h05);
      chk(32'(active_channel), 32'h0000_0003);
      chk(32'(active_reference), 32'h0000_0002);
      while (conv_busy === 1'b1) @(posedge clk);
      repeat (3) @(posedge clk);
      chk(32'(active_channel), 32'h0000_0005);
   endtask

   // level held and edges inside a conversion start nothing
   task automatic t_trig();
      wr(SAC_OFF_CTLB, 8'h32);
      chk(32'(active_gain), 32'h0000_0003);
      ctla_v = 8'hA0;
      wr(SAC_OFF_CTLA, ctla_v);
      trig_in <= 8'h08;
      repeat (10) @(posedge clk);
      chk(32'(conv_busy), 32'h0000_0000);
      trig_in <= 8'h0C;
      repeat (4) @(posedge clk);
      chk(32'(conv_busy), 32'h0000_0001);
      wb(1'b0, SAC_OFF_CTLA, 8'h00, q);
      chk(q & 32'h0000_0040, 32'h0000_0040);
      trig_in <= 8'h08;
      @(posedge clk);
      trig_in <= 8'h0C;
      while (conv_busy === 1'b1) @(posedge clk);
      repeat (40) @(posedge clk);
      chk(32'(conv_busy), 32'h0000_0000);
      run(10'h001, n);
      chk(32'(n >= 20 && n <= 32), 32'h0000_0001);
      // source flag cleared, then set again: a fresh edge starts one more run
      trig_in <= 8'h08;
      @(posedge clk);
      trig_in <= 8'h0C;
      repeat (4) @(posedge clk);
      chk(32'(conv_busy), 32'h0000_0001);
      while (conv_busy === 1'b1) @(posedge clk);
      trig_in <= 8'h00;
   endtask

   // completion flag as trigger chains conversions without clearing
   task automatic t_free();
      wr(SAC_OFF_CTLB, 8'h00);
      wr(SAC_OFF_CTLA, 8'hE0); // single ended channel 5 stays selected
      n = 0;
      repeat (200) begin
         @(posedge clk);
         if (sample_start === 1'b1)
            n++;
      end
      chk(32'(n >= 5), 32'h0000_0001);
      wr(SAC_OFF_CTLA, 8'h00);
      n = 0;
      repeat (60) begin
         @(posedge clk);
         if (sample_start === 1'b1)
            n++;
      end
      chk(32'(n), 32'h0000_0000);
      chk(32'(conv_busy), 32'h0000_0000);
      chk(32'(converter_on), 32'h0000_0000);
   endtask

   // flag leaves by vector taken or by writing one
   task automatic t_irq();
      ctla_v = 8'h88;
      wr(SAC_OFF_CTLA, ctla_v);
      chk(32'(conv_irq), 32'h0000_0001);
      vector_taken <= 1'b1;
      @(posedge clk);
      vector_taken <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(conv_irq), 32'h0000_0000);
      run(10'h0F0, n);
      chk(32'(conv_irq), 32'h0000_0001);
      wr(SAC_OFF_CTLA, 8'h98);
      wb(1'b0, SAC_OFF_CTLA, 8'h00, q);
      chk(q, 32'h0000_0088);
   endtask

   // long enough for all scenarios with margin
   initial begin
      #400_000;
      miscompares++;
      results();
   end

   initial begin
      miscompares = 0;
      n_checks = 0;
      ctla_v = 8'h80;
      reset = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h0000_0000;
      trig_in = 8'h00;
      analog_result = 10'h000;
      vector_taken = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      t_basic();
      t_lock();
      t_chan();
      t_trig();
      t_free();
      t_irq();
      results();
   end
endmodule
